// ### core/ccp_port.sv
// Codec control port: three-wire and two-wire register access
// Behaviour
// - Prepare-read starts with write-type address, select bit from pin.
// - Register byte with leading 1 stores the address for reading.
// - Address with transfer bits 11 makes the device transmit.
// - Device returns register address, first bit 0 valid, 1 invalid.
// - Then upper data byte, then lower data byte.
// - Both links reach the same register addresses and contents.
// - Two-wire: never drive clock, drive data only to send or ack.
// - First byte after START is the slave address; answer on match.
// - Slave address fixed except lowest bit from select pin.
// - Addresses one byte each, data items two bytes.
// - Write: START, address with write bit, register byte, all acked.
// - Upper then lower data byte, each acknowledged.
// - Data line released after final write acknowledge.
// - Register address increments after each two-byte group.
// - Read: upper then lower byte, host acks to continue.
// - Host NACK ends read; device releases data line.
// - Three-wire address byte: mode low, eight clock pulses.
// - Three-wire address byte goes least significant bit first; register and data bytes most significant bit first.
// - Sample on rising edge, launch read data on falling edge.
// - Foreign three-wire address deselects the port.
`timescale 1ns/1ps
module ccp_port (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic link_select_i,
    input wire logic address_select_pin_i,
    input wire logic ctrl_serial_clock_line_i,
    input wire logic ctrl_frame_type_line_i,
    input wire logic ctrl_serial_data_line_i,
    output logic ctrl_serial_data_line_o,
    output logic ctrl_serial_data_line_oe_o,
    output logic [6:0] reg_addr_o,
    output logic [15:0] reg_wdata_o,
    output logic reg_we_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_valid_i
);
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            rev8[i] = b[7 - i];
        end
    endfunction : rev8

    // Link domain, clocked by the three-wire clock line
    wire logic lclk = ctrl_serial_clock_line_i;
    logic lsel1_q, lsel2_q, lip1_q, lip2_q;
    logic [6:0] sr_q;
    logic [2:0] bcnt_q;
    logic mlast_q, sel_q, rd_q, wtog_q, rtog_q;
    logic [1:0] idx_q;
    logic [6:0] waddr_q, raddr_q;
    logic [7:0] upper_q;
    logic [15:0] wdata_q;
    logic [4:0] tptr_q;
    logic l3_out_q, l3_oe_q;
    logic [15:0] hold_q;
    logic hold_inv_q;

    wire logic mode = ctrl_frame_type_line_i;
    wire logic fresh = mode != mlast_q;
    wire logic [2:0] pos = fresh ? 3'h0 : bcnt_q;
    wire logic [7:0] l3_byte = {ctrl_serial_data_line_i, sr_q};
    wire logic [7:0] l3_rv = rev8(l3_byte);
    wire logic l3_done = pos == ccp_pkg::L3_LAST_BIT;
    wire logic l3_match = l3_byte[7:3] == ccp_pkg::L3_DEV_HI
        && l3_byte[2] == lip2_q && l3_byte[1];
    wire logic l3_dat = l3_done && mode && sel_q && !rd_q && !lsel2_q;
    wire logic [23:0] l3_tx = {rev8(hold_q[7:0]), rev8(hold_q[15:8]),
        rev8({hold_inv_q, raddr_q})};

    always_ff @(posedge lclk or posedge rst_i)
    begin
        if (rst_i)
        begin
            lsel1_q <= 1'b0;
            lsel2_q <= 1'b0;
            lip1_q <= 1'b0;
            lip2_q <= 1'b0;
            sr_q <= 7'h00;
            bcnt_q <= 3'h0;
            mlast_q <= 1'b0;
        end
        else
        begin
            lsel1_q <= link_select_i;
            lsel2_q <= lsel1_q;
            lip1_q <= address_select_pin_i;
            lip2_q <= lip1_q;
            sr_q <= l3_byte[7:1];
            bcnt_q <= pos + 3'h1;
            mlast_q <= mode;
        end
    end

    always_ff @(posedge lclk or posedge rst_i)
    begin
        if (rst_i)
        begin
            sel_q <= 1'b0;
            rd_q <= 1'b0;
            idx_q <= 2'h0;
            tptr_q <= 5'h00;
        end
        else if (l3_done && !mode)
        begin
            sel_q <= l3_match;
            rd_q <= l3_match && l3_byte[0];
            idx_q <= 2'h0;
            tptr_q <= 5'h00;
        end
        else
        begin
            if (rd_q && mode && tptr_q < ccp_pkg::L3_TX_BITS)
            begin
                tptr_q <= tptr_q + 5'h01;
            end
            if (l3_dat)
            begin
                idx_q <= (idx_q == 2'h0 && l3_rv[7]) ? 2'h0
                    : (idx_q == 2'h1 ? 2'h2 : 2'h1);
            end
        end
    end

    // Held words are read by the system side only after their toggle
    always_ff @(posedge lclk or posedge rst_i)
    begin
        if (rst_i)
        begin
            waddr_q <= ccp_pkg::ADDR_RST;
            raddr_q <= ccp_pkg::ADDR_RST;
            upper_q <= 8'h00;
            wdata_q <= ccp_pkg::DATA_RST;
            wtog_q <= 1'b0;
            rtog_q <= 1'b0;
        end
        else if (l3_dat)
        begin
            if (idx_q == 2'h0 && l3_rv[7])
            begin
                raddr_q <= l3_rv[6:0];
                rtog_q <= !rtog_q;
            end
            else if (idx_q == 2'h0)
            begin
                waddr_q <= l3_rv[6:0];
            end
            else if (idx_q == 2'h1)
            begin
                upper_q <= l3_rv;
            end
            else
            begin
                wdata_q <= {upper_q, l3_rv};
                wtog_q <= !wtog_q;
            end
        end
    end

    // Read data is launched on the falling edge, host samples on rising
    always_ff @(negedge lclk or posedge rst_i)
    begin
        if (rst_i)
        begin
            l3_out_q <= 1'b0;
            l3_oe_q <= 1'b0;
        end
        else
        begin
            l3_out_q <= tptr_q < ccp_pkg::L3_TX_BITS
                ? l3_tx[tptr_q] : 1'b0;
            l3_oe_q <= rd_q && tptr_q < ccp_pkg::L3_TX_BITS && !lsel2_q;
        end
    end

    // System domain: synchronisers
    logic [2:0] wt_q, rt_q;
    logic scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q;
    logic isel1_q, isel2_q, ip1_q, ip2_q;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wt_q <= 3'h0;
            rt_q <= 3'h0;
            {scl1_q, scl2_q, scl3_q} <= 3'h7;
            {sda1_q, sda2_q, sda3_q} <= 3'h7;
            {isel1_q, isel2_q, ip1_q, ip2_q} <= 4'h0;
        end
        else
        begin
            wt_q <= {wt_q[1:0], wtog_q};
            rt_q <= {rt_q[1:0], rtog_q};
            {scl1_q, scl2_q, scl3_q} <= {ctrl_serial_clock_line_i,
                scl1_q, scl2_q};
            {sda1_q, sda2_q, sda3_q} <= {ctrl_serial_data_line_i,
                sda1_q, sda2_q};
            {isel1_q, isel2_q} <= {link_select_i, isel1_q};
            {ip1_q, ip2_q} <= {address_select_pin_i, ip1_q};
        end
    end

    wire logic l3_wr_ev = (wt_q[2] != wt_q[1]) && !isel2_q;
    wire logic l3_rd_ev = (rt_q[2] != rt_q[1]) && !isel2_q;
    wire logic i_start = scl2_q && scl3_q && sda3_q && !sda2_q;
    wire logic i_stop = scl2_q && scl3_q && !sda3_q && sda2_q;
    wire logic i_rise = scl2_q && !scl3_q;
    wire logic i_fall = !scl2_q && scl3_q;

    ccp_pkg::ccp_i2c_state_e st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, tx_q, iup_q;
    logic [6:0] ptr_q;
    logic oe_q, lo_q, mack_q, fetch_q;
    // No ack slot while idle: the bit count stalls there after a mismatch
    wire logic slot = i_fall && cnt_q == ccp_pkg::I2C_ACK_SLOT
        && st_q != ccp_pkg::CCP_IDLE;
    wire logic after = i_fall && cnt_q == ccp_pkg::I2C_ACK_DONE;
    wire logic i_match = sh_q[7:2] == ccp_pkg::I2C_DEV_HI
        && sh_q[1] == ip2_q;
    wire logic i_wr_ev = slot && st_q == ccp_pkg::CCP_WR && lo_q;
    wire logic [7:0] next_tx = lo_q ? reg_rdata_i[7:0] : reg_rdata_i[15:8];

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= ccp_pkg::CCP_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            iup_q <= 8'h00;
            ptr_q <= ccp_pkg::ADDR_RST;
            oe_q <= 1'b0;
            lo_q <= 1'b0;
            mack_q <= 1'b0;
        end
        else if (i_start || i_stop || !isel2_q)
        begin
            st_q <= (i_start && isel2_q) ? ccp_pkg::CCP_DEV
                : ccp_pkg::CCP_IDLE;
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
        end
        else if (i_rise && st_q != ccp_pkg::CCP_IDLE)
        begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q < ccp_pkg::I2C_ACK_SLOT)
            begin
                sh_q <= {sh_q[6:0], sda2_q};
            end
            else
            begin
                mack_q <= sda2_q;
            end
        end
        else if (slot)
        begin
            oe_q <= st_q != ccp_pkg::CCP_RD;
            case (st_q)
                ccp_pkg::CCP_DEV:
                begin
                    oe_q <= i_match;
                    lo_q <= 1'b0;
                    st_q <= !i_match ? ccp_pkg::CCP_IDLE
                        : (sh_q[0] ? ccp_pkg::CCP_RD
                        : ccp_pkg::CCP_REG);
                end
                ccp_pkg::CCP_REG:
                begin
                    ptr_q <= sh_q[6:0];
                    st_q <= ccp_pkg::CCP_WR;
                end
                ccp_pkg::CCP_WR:
                begin
                    iup_q <= sh_q;
                    lo_q <= !lo_q;
                    ptr_q <= ptr_q + {6'h00, lo_q};
                end
                ccp_pkg::CCP_RD:
                begin
                    ptr_q <= ptr_q + {6'h00, lo_q};
                    lo_q <= !lo_q;
                end
                default:
                begin
                    st_q <= ccp_pkg::CCP_IDLE;
                end
            endcase
        end
        else if (after)
        begin
            cnt_q <= 4'h0;
            oe_q <= 1'b0;
            tx_q <= {next_tx[6:0], 1'b0};
            if (st_q == ccp_pkg::CCP_RD && mack_q)
            begin
                st_q <= ccp_pkg::CCP_IDLE;
            end
            else if (st_q == ccp_pkg::CCP_RD)
            begin
                oe_q <= !next_tx[7];
            end
        end
        else if (i_fall && st_q == ccp_pkg::CCP_RD && cnt_q != 4'h0)
        begin
            oe_q <= !tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
        else if (i_fall && st_q == ccp_pkg::CCP_RD)
        begin
            mack_q <= 1'b0;
        end
    end

    // Both links write the same register map
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_addr_o <= ccp_pkg::ADDR_RST;
            reg_wdata_o <= ccp_pkg::DATA_RST;
            reg_we_o <= 1'b0;
            fetch_q <= 1'b0;
            hold_q <= ccp_pkg::DATA_RST;
            hold_inv_q <= 1'b0;
        end
        else
        begin
            reg_we_o <= l3_wr_ev || i_wr_ev;
            reg_wdata_o <= l3_wr_ev ? wdata_q
                : (i_wr_ev ? {iup_q, sh_q} : reg_wdata_o);
            reg_addr_o <= l3_wr_ev ? waddr_q
                : (l3_rd_ev ? raddr_q
                : (isel2_q ? ptr_q : reg_addr_o));
            fetch_q <= l3_rd_ev;
            if (fetch_q)
            begin
                hold_q <= reg_rdata_i;
                hold_inv_q <= !reg_valid_i;
            end
        end
    end

    // Two-wire mode only ever pulls the data line low
    assign ctrl_serial_data_line_o = isel2_q ? 1'b0 : l3_out_q;
    assign ctrl_serial_data_line_oe_o = isel2_q ? oe_q : l3_oe_q;

    a_i2c_low_only: assert property (
        @(posedge clock_i) disable iff (rst_i)
        isel2_q && ctrl_serial_data_line_oe_o |->
        !ctrl_serial_data_line_o)
        else $error("two-wire data driven high");
    a_dev_ack_match: assert property (
        @(posedge clock_i) disable iff (rst_i)
        slot && st_q == ccp_pkg::CCP_DEV && i_match && !i_start && !i_stop
        |=> oe_q && st_q != ccp_pkg::CCP_IDLE)
        else $error("matching address not acked");
    a_dev_no_match: assert property (
        @(posedge clock_i) disable iff (rst_i)
        slot && st_q == ccp_pkg::CCP_DEV && !i_match && !i_start && !i_stop
        |=> !oe_q && st_q == ccp_pkg::CCP_IDLE)
        else $error("foreign address answered");
    a_reg_byte_ack: assert property (
        @(posedge clock_i) disable iff (rst_i)
        slot && st_q == ccp_pkg::CCP_REG && !i_start && !i_stop
        |=> oe_q ##0 st_q == ccp_pkg::CCP_WR)
        else $error("register byte not acked");
    a_write_pulse: assert property (
        @(posedge clock_i) disable iff (rst_i)
        i_wr_ev && !i_start && !i_stop |=> reg_we_o
        && reg_addr_o == $past(ptr_q) ##1 !reg_we_o
        && ptr_q == $past(ptr_q, 2) + 7'h01)
        else $error("write group or increment wrong");
    a_ack_release: assert property (
        @(posedge clock_i) disable iff (rst_i)
        after && st_q != ccp_pkg::CCP_RD |=> !oe_q)
        else $error("data line held after ack");
    a_nack_release: assert property (
        @(posedge clock_i) disable iff (rst_i)
        after && st_q == ccp_pkg::CCP_RD && mack_q && !i_start && !i_stop
        |=> !oe_q && st_q == ccp_pkg::CCP_IDLE)
        else $error("data line held after nack");
    a_l3_deselect: assert property (
        @(posedge lclk) disable iff (rst_i)
        l3_done && !mode && !l3_match |=> !sel_q && !rd_q)
        else $error("foreign device address kept");
endmodule : ccp_port

// ### core/ccp_pkg.sv
// Constants and types shared by the codec control port
package ccp_pkg;
    // Fixed part of the three-wire device address, bits 7..3
    localparam logic [4:0] L3_DEV_HI = 5'h02;
    // Fixed part of the two-wire slave address, bits 7..2 of the byte
    localparam logic [5:0] I2C_DEV_HI = 6'h0D;
    localparam logic [2:0] L3_LAST_BIT = 3'h7;
    localparam logic [4:0] L3_TX_BITS = 5'h18;
    localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
    localparam logic [3:0] I2C_ACK_DONE = 4'h9;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;
    typedef enum logic [2:0] {
        CCP_IDLE = 3'b000,
        CCP_DEV = 3'b001,
        CCP_REG = 3'b010,
        CCP_WR = 3'b011,
        CCP_RD = 3'b100
    } ccp_i2c_state_e;
endpackage : ccp_pkg

// ### bench/ccp_host.sv
// Host model: serial bus master for both links of the control port
`timescale 1ns/1ps
module ccp_host (
    input wire logic sda_i,
    output logic scl_o,
    output logic mode_o,
    output logic sda_o
);
    localparam realtime L3_HALF = 62.5;
    // Two-wire half period kept well above eight system clocks
    localparam realtime TW_HALF = 250.0;
    initial
    begin
        scl_o = 1'b1;
        mode_o = 1'b1;
        sda_o = 1'b1;
    end
    // Bit b[7] goes first in time; clock stands high between bytes
    task automatic l3_byte(input logic m, input logic [7:0] b);
        mode_o = m;
        for (int i = 7; i >= 0; i--)
        begin
            scl_o = 1'b0;
            sda_o = b[i];
            #(L3_HALF);
            scl_o = 1'b1;
            #(L3_HALF);
        end
    endtask : l3_byte
    task automatic l3_read(output logic [23:0] r);
        mode_o = 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            scl_o = 1'b0;
            #(L3_HALF);
            scl_o = 1'b1;
            r = {r[22:0], sda_i};
            #(L3_HALF);
        end
    endtask : l3_read
    // Serves as START and as repeated START
    task automatic tw_start();
        sda_o = 1'b1;
        #(TW_HALF);
        scl_o = 1'b1;
        #(TW_HALF);
        sda_o = 1'b0;
        #(TW_HALF);
        scl_o = 1'b0;
    endtask : tw_start
    task automatic tw_stop();
        #(TW_HALF / 2);
        sda_o = 1'b0;
        #(TW_HALF / 2);
        scl_o = 1'b1;
        #(TW_HALF);
        sda_o = 1'b1;
        #(TW_HALF);
    endtask : tw_stop
    // Data changes mid-low so it never races the clock edge
    task automatic tw_bit(input logic v, output logic s);
        #(TW_HALF / 2);
        sda_o = v;
        #(TW_HALF / 2);
        scl_o = 1'b1;
        #(TW_HALF);
        s = sda_i;
        scl_o = 1'b0;
    endtask : tw_bit
    // Pass b all ones to read; a is the ninth bit, s its sampled level
    task automatic tw_byte(input logic [7:0] b, input logic a,
                           output logic [7:0] r, output logic s);
        for (int i = 7; i >= 0; i--)
            tw_bit(b[i], r[i]);
        tw_bit(a, s);
    endtask : tw_byte
endmodule : ccp_host

// ### bench/tb.sv
// Testbench for the codec control port
`timescale 1ns/1ps
module tb;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic link_sel = 1'b0;
    logic sel = 1'b0;
    logic sda_o, sda_oe, we, scl, mode, host_sda;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic [15:0] regs [0:127];
    int fail_count = 0;
    int checks = 0;
    int we_count = 0;
    function automatic logic isv(input logic [6:0] a);
        return a inside {7'h00, 7'h01, 7'h10, 7'h11, 7'h12, 7'h20, 7'h21,
                         7'h30};
    endfunction : isv
    // Two-wire line has a pull-up; the device has no clock output
    wire sda = link_sel ? (~sda_oe & host_sda)
                        : (sda_oe ? sda_o : host_sda);
    wire valid = isv(addr);
    ccp_port uut (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .link_select_i(link_sel),
        .address_select_pin_i(sel),
        .ctrl_serial_clock_line_i(scl),
        .ctrl_frame_type_line_i(mode),
        .ctrl_serial_data_line_i(sda),
        .ctrl_serial_data_line_o(sda_o),
        .ctrl_serial_data_line_oe_o(sda_oe),
        .reg_addr_o(addr),
        .reg_wdata_o(wdata),
        .reg_we_o(we),
        .reg_rdata_i(regs[addr]),
        .reg_valid_i(valid)
    );
    ccp_host host (
        .sda_i(sda),
        .scl_o(scl),
        .mode_o(mode),
        .sda_o(host_sda)
    );
    initial
    begin
        forever #12.5 clock_i = ~clock_i;
    end
    initial
    begin
        for (int i = 0; i < 128; i++)
            regs[i] = 16'h0000;
    end
    always @(posedge clock_i)
    begin
        if (we === 1'b1)
        begin
            regs[addr] <= wdata;
            we_count++;
        end
    end
    task automatic chk(input bit ok, input string m);
        checks++;
        if (!ok)
        begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] dev3(input logic d0, input logic s);
        return {d0, 1'b1, s, 5'h08};
    endfunction : dev3
    function automatic logic [7:0] dev2(input logic rw, input logic s);
        return {6'h0D, s, rw};
    endfunction : dev2
    task automatic t_l3_rw(input logic [6:0] a, input logic [15:0] d);
        logic [23:0] r;
        host.l3_byte(1'b0, dev3(1'b0, sel));
        host.l3_byte(1'b1, {1'b0, a});
        host.l3_byte(1'b1, d[15:8]);
        host.l3_byte(1'b1, d[7:0]);
        repeat (10) @(posedge clock_i);
        chk(!isv(a) || regs[a] === d, "three-wire write");
        host.l3_byte(1'b0, dev3(1'b0, sel));
        host.l3_byte(1'b1, {1'b1, a});
        repeat (12) @(posedge clock_i);
        host.l3_byte(1'b0, dev3(1'b1, sel));
        host.l3_read(r);
        chk(r === {~isv(a), a, regs[a]}, "three-wire read");
    endtask : t_l3_rw
    task automatic t_l3_foreign();
        int n;
        n = we_count;
        host.l3_byte(1'b0, dev3(1'b0, ~sel));
        host.l3_byte(1'b1, 8'h10);
        host.l3_byte(1'b1, 8'hFF);
        host.l3_byte(1'b1, 8'hFF);
        repeat (10) @(posedge clock_i);
        chk(we_count == n && sda_oe === 1'b0, "foreign address");
    endtask : t_l3_foreign
    task automatic tw_head(input logic [6:0] a);
        logic [7:0] r;
        logic s;
        host.tw_start();
        host.tw_byte(dev2(1'b0, sel), 1'b1, r, s);
        chk(s === 1'b0, "slave address ack");
        host.tw_byte({1'b0, a}, 1'b1, r, s);
        chk(s === 1'b0, "register ack");
    endtask : tw_head
    task automatic t_tw_write(input logic [6:0] a, input logic [31:0] d);
        logic [7:0] r;
        logic s;
        tw_head(a);
        for (int i = 0; i < 4; i++)
        begin
            host.tw_byte(d[31 - 8 * i -: 8], 1'b1, r, s);
            chk(s === 1'b0, "data ack");
        end
        repeat (8) @(posedge clock_i);
        chk(sda === 1'b1, "line freed after write");
        host.tw_stop();
        chk({regs[a], regs[a + 7'h01]} === d, "two-wire write");
    endtask : t_tw_write
    task automatic t_tw_read(input logic [6:0] a);
        logic [31:0] e, g;
        logic [7:0] r;
        logic s;
        e = {regs[a], regs[a + 7'h01]};
        tw_head(a);
        host.tw_start();
        host.tw_byte(dev2(1'b1, sel), 1'b1, r, s);
        chk(s === 1'b0, "read address ack");
        for (int i = 0; i < 4; i++)
        begin
            host.tw_byte(8'hFF, i == 3, r, s);
            g = {g[23:0], r};
        end
        chk(g === e, "two-wire read");
        repeat (8) @(posedge clock_i);
        chk(sda === 1'b1 && sda_oe === 1'b0, "freed after NACK");
        host.tw_stop();
    endtask : t_tw_read
    task automatic t_tw_foreign();
        logic [7:0] r;
        logic s;
        int n;
        n = we_count;
        host.tw_start();
        host.tw_byte(dev2(1'b0, ~sel), 1'b1, r, s);
        chk(s === 1'b1, "no ack to foreign address");
        host.tw_byte(8'h20, 1'b1, r, s);
        chk(s === 1'b1 && we_count == n, "idle after mismatch");
        host.tw_stop();
    endtask : t_tw_foreign
    initial
    begin
        repeat (100000) @(posedge clock_i);
        chk(1'b0, "timeout");
        give_verdict();
    end
    initial
    begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        // Wake-up pulses let the link-side strap synchronisers settle
        host.l3_byte(1'b1, 8'h00);
        t_l3_rw(7'h11, 16'hA55A);
        t_l3_rw(7'h12, 16'h3CC3);
        t_l3_rw(7'h05, 16'h1234);
        t_l3_foreign();
        @(posedge clock_i);
        link_sel <= 1'b1;
        sel <= 1'b1;
        rst_i <= 1'b1;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        t_tw_write(7'h20, 32'hBEEF_0F0F);
        t_tw_read(7'h11);
        t_tw_read(7'h20);
        t_tw_foreign();
        give_verdict();
    end
endmodule : tb
